// ---- lpd_burst.sv ----
// Burst-pattern duty generator: 2**W pulses per period, each split in halves.
`timescale 1ns/10ps
`default_nettype none
module lpd_burst #(
    parameter int unsigned W = 8
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         half_tick,
    input  wire logic [W-1:0] duty,
    output var  logic         on_q
);
    // Half-slot index h; its bit-reversal spreads the 2N lit halves evenly.
    // At mid-scale every pulse gets its first half lit, i.e. 50 % pulses;
    // above that whole pulses fill in, below it whole pulses drop out.
    logic [W:0] h_q;
    logic [W:0] h_d;
    logic [W:0] rev;
    logic       on_d;

    always_comb begin
        for (int i = 0; i <= W; i++) begin
            rev[i] = h_q[W-i];
        end
        h_d  = half_tick ? h_q + 1'b1 : h_q;
        on_d = ({1'b0, rev} < {duty, 1'b0});
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            h_q  <= '0;
            on_q <= 1'b0;
        end else begin
            h_q  <= h_d;
            on_q <= on_d;
        end
    end
endmodule
`default_nettype wire

// ---- lpd_pkg.sv ----
// Shared constants for the LED and peripheral PWM driver block.
package lpd_pkg;

    // ========================================================================
    // Clock and timing
    // ========================================================================
    localparam int unsigned CLK_HZ          = 200_000_000;
    localparam int unsigned MAX_ON_NS       = 6000;
    localparam int unsigned MAX_ON_CYC      = (MAX_ON_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned SOFT_STEP_CYC   = 256;
    localparam int unsigned FLASH_TICK_MS   = 100;
    localparam int unsigned FLASH_TICK_CYC  = (CLK_HZ / 1000) * FLASH_TICK_MS;

    // ========================================================================
    // Burst pattern generators
    // ========================================================================
    localparam int unsigned BURST_W         = 8;
    localparam int unsigned BURST_SLOTS     = 256;
    localparam int unsigned RATE_HI_HZ      = 180;
    localparam int unsigned RATE_LO_HZ      = 122;
    localparam int unsigned BURST_DIV_HI    = CLK_HZ / (RATE_HI_HZ * BURST_SLOTS * 2);
    localparam int unsigned BURST_DIV_LO    = CLK_HZ / (RATE_LO_HZ * BURST_SLOTS * 2);
    localparam int unsigned RGB_W           = 5;
    localparam int unsigned RGB_SLOTS       = 32;
    localparam int unsigned RGB_REP_HZ      = 1000;
    localparam int unsigned RGB_DIV         = CLK_HZ / (RGB_REP_HZ * RGB_SLOTS * 2);
    localparam int unsigned DIV_W           = 24;

    // ========================================================================
    // General PWM: frequencies in tenths of a hertz, 16 duty steps
    // ========================================================================
    localparam int unsigned PWM_STEPS       = 16;
    localparam int unsigned PWM_F10_0       = 5000;
    localparam int unsigned PWM_F10_1       = 10000;
    localparam int unsigned PWM_F10_2       = 15000;
    localparam int unsigned PWM_F10_3       = 20000;
    localparam int unsigned PWM_F10_4       = 30000;
    localparam int unsigned PWM_F10_5       = 45000;
    localparam int unsigned PWM_F10_6       = 78000;
    localparam int unsigned PWM_F10_7       = 156000;

    function automatic logic [DIV_W-1:0] pwm_div(input logic [2:0] sel);
        longint unsigned f10;
        case (sel)
            3'h0:    f10 = PWM_F10_0;
            3'h1:    f10 = PWM_F10_1;
            3'h2:    f10 = PWM_F10_2;
            3'h3:    f10 = PWM_F10_3;
            3'h4:    f10 = PWM_F10_4;
            3'h5:    f10 = PWM_F10_5;
            3'h6:    f10 = PWM_F10_6;
            default: f10 = PWM_F10_7;
        endcase
        return DIV_W'((longint'(CLK_HZ) * 10) / (f10 * PWM_STEPS));
    endfunction

    // ========================================================================
    // Boost current limit codes and Tricolour_blink_config timing
    // ========================================================================
    localparam logic [1:0] LIM_OFF          = 2'h0;
    localparam logic [1:0] LIM_125MA        = 2'h1;
    localparam logic [1:0] LIM_250MA        = 2'h2;
    localparam logic [1:0] LIM_500MA        = 2'h3;
    localparam logic [6:0] HALF_SEC_TICKS   = 7'h05;
    localparam logic [6:0] ON_TICKS_MAX     = 7'h06;

    typedef enum logic [1:0] {
        LPD_OFF   = 2'b00,
        LPD_STEP1 = 2'b01,
        LPD_STEP2 = 2'b11,
        LPD_RUN   = 2'b10
    } lpd_boost_t;

endpackage

// ---- lpd_plant.sv ----
// Behavioural power stage: inductor ramp to the peak limit and LED current sense.
`timescale 1ns/10ps
`default_nettype none
module lpd_plant (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       boost_switch_q,
    input  wire logic [1:0] boost_limit_q,
    input  wire logic       slow,
    output var  logic       peak_limit_hit,
    output var  logic       sense_below_ref
);
    logic [7:0] ramp_q;
    logic [1:0] rest_q;
    // A higher limit takes longer to reach; slow mode never reaches it, so the on-time cap must act.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ramp_q          <= 8'h00;
            rest_q          <= 2'h0;
            peak_limit_hit  <= 1'b0;
            sense_below_ref <= 1'b0;
        end else begin
            ramp_q          <= boost_switch_q ? ramp_q + 8'h01 : 8'h00;
            peak_limit_hit  <= boost_switch_q && !slow && (ramp_q >= {4'h0, boost_limit_q, 2'h0});
            rest_q          <= boost_switch_q ? 2'h3 : (rest_q != 2'h0 ? rest_q - 2'h1 : 2'h0);
            sense_below_ref <= !boost_switch_q && (rest_q == 2'h0);
        end
    end
endmodule
`default_nettype wire

// ---- lpd_properties.sv ----
// Concurrent checks on the LED and peripheral driver top-level ports.
`timescale 1ns/10ps
`default_nettype none
module lpd_properties (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       sense_below_ref,
    input wire logic       peak_limit_hit,
    input wire logic       boost_overvoltage,
    input wire logic       low_supply_lockout,
    input wire logic       thermal_shutdown,
    input wire logic [7:0] boost_duty_setting,
    input wire logic       burst_rate_select_bit,
    input wire logic [2:0] pwm_freq_sel,
    input wire logic [3:0] pwm_duty_sel,
    input wire logic [7:0] backlight_duty_setting,
    input wire logic       flash_enable,
    input wire logic [3:0] flash_period_sel,
    input wire logic [2:0] flash_on_sel,
    input wire logic [1:0] flash_phase_sel,
    input wire logic [1:0] sink_current_sel,
    input wire logic [4:0] red_duty_setting,
    input wire logic [4:0] green_duty_setting,
    input wire logic [4:0] blue_duty_setting,
    input wire logic       boost_switch_q,
    input wire logic       led_switch_q,
    input wire logic [1:0] boost_limit_q,
    input wire logic       boost_active_q,
    input wire logic       pwm_od_out_q,
    input wire logic       pwm_od_oe_n_q,
    input wire logic       backlight_pwm_q,
    input wire logic [2:0] rgb_sink_on_q,
    input wire logic [1:0] rgb_current_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ========================================================================
    // Helper: length of the present closed-switch interval
    // ========================================================================
    logic [15:0] on_cnt_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            on_cnt_q <= 16'h0000;
        end else begin
            on_cnt_q <= boost_switch_q ? on_cnt_q + 16'h0001 : 16'h0000;
        end
    end
    // ========================================================================
    // Properties
    // ========================================================================
    property p_close;
        $rose(boost_switch_q) |-> $past(led_switch_q) && $past(sense_below_ref, 3) && boost_active_q;
    endproperty
    a_close: assert property (p_close) else $error("switch closed without LED switch");
    property p_peak; peak_limit_hit [*3] |=> !boost_switch_q; endproperty
    a_peak: assert property (p_peak) else $error("switch stayed closed at peak");
    property p_max_on; boost_switch_q |-> on_cnt_q <= 16'd1200; endproperty
    a_max_on: assert property (p_max_on) else $error("switch on beyond 6 us");
    property p_led_off; !led_switch_q [*2] |-> !boost_switch_q; endproperty
    a_led_off: assert property (p_led_off) else $error("switch closed with LED off");
    property p_ss_start; $rose(boost_active_q) |-> boost_limit_q == lpd_pkg::LIM_125MA; endproperty
    a_ss_start: assert property (p_ss_start) else $error("soft start not at lowest limit");
    property p_ss_step;
        boost_active_q && $past(boost_active_q) && (boost_limit_q != $past(boost_limit_q))
            |-> boost_limit_q == $past(boost_limit_q) + 2'h1;
    endproperty
    a_ss_step: assert property (p_ss_step) else $error("limit skipped a step");
    property p_zero_duty; (boost_duty_setting == 8'h00) [*2] |-> !boost_active_q && !boost_switch_q; endproperty
    a_zero_duty: assert property (p_zero_duty) else $error("converter on with zero duty");
    property p_ovp; boost_overvoltage [*3] |=> !boost_switch_q; endproperty
    a_ovp: assert property (p_ovp) else $error("switch closed in overvoltage");
    property p_lock; (low_supply_lockout || thermal_shutdown) [*4] |-> !boost_switch_q && !led_switch_q; endproperty
    a_lock: assert property (p_lock) else $error("switches closed in lockout");
    property p_bl_zero; (backlight_duty_setting == 8'h00) [*2] |-> !backlight_pwm_q; endproperty
    a_bl_zero: assert property (p_bl_zero) else $error("backlight on at zero duty");
    property p_rgb_off; !flash_enable [*2] |-> rgb_sink_on_q == 3'h0 && rgb_current_q == 2'h0; endproperty
    a_rgb_off: assert property (p_rgb_off) else $error("sinks on without enable");
    property p_rgb_cur; flash_enable |=> rgb_current_q == $past(sink_current_sel); endproperty
    a_rgb_cur: assert property (p_rgb_cur) else $error("sink current code wrong");
    property p_od; (pwm_duty_sel == 4'h0) [*2] |-> pwm_od_oe_n_q && !pwm_od_out_q; endproperty
    a_od: assert property (p_od) else $error("open drain pulled at zero duty");
endmodule
bind lpd_top lpd_properties lpd_properties_inst (.*);
`default_nettype wire

// ---- lpd_tick.sv ----
// Programmable divider that emits a one-cycle enable pulse.
`timescale 1ns/10ps
`default_nettype none
module lpd_tick (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic [lpd_pkg::DIV_W-1:0] period,
    output var  logic                     tick_q
);
    logic [lpd_pkg::DIV_W-1:0] cnt_q;
    logic [lpd_pkg::DIV_W-1:0] cnt_d;
    logic                      tick_d;

    always_comb begin
        tick_d = 1'b0;
        cnt_d  = cnt_q + 1'b1;
        if (cnt_q >= period - 1'b1) begin
            cnt_d  = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end
endmodule
`default_nettype wire

// ---- lpd_top.sv ----
// White-LED boost control, general PWM, backlight PWM and RGB flasher.
`timescale 1ns/10ps
`default_nettype none
module lpd_top #(
    parameter int unsigned FLASH_TICK_CYC = lpd_pkg::FLASH_TICK_CYC,
    parameter int unsigned PWM_DIV_SCALE  = 1
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Analog comparator and supervisor levels, asynchronous to clk.
    input  wire logic       sense_below_ref,
    input  wire logic       peak_limit_hit,
    input  wire logic       boost_overvoltage,
    input  wire logic       low_supply_lockout,
    input  wire logic       thermal_shutdown,
    // Settings from the register logic on clk.
    input  wire logic [7:0] boost_duty_setting,
    input  wire logic       burst_rate_select_bit,
    input  wire logic [2:0] pwm_freq_sel,
    input  wire logic [3:0] pwm_duty_sel,
    input  wire logic [7:0] backlight_duty_setting,
    input  wire logic       flash_enable,
    input  wire logic [3:0] flash_period_sel,
    input  wire logic [2:0] flash_on_sel,
    input  wire logic [1:0] flash_phase_sel,
    input  wire logic [1:0] sink_current_sel,
    input  wire logic [4:0] red_duty_setting,
    input  wire logic [4:0] green_duty_setting,
    input  wire logic [4:0] blue_duty_setting,
    // Power stage, general PWM and LED outputs.
    output var  logic       boost_switch_q,
    output var  logic       led_switch_q,
    output var  logic [1:0] boost_limit_q,
    output var  logic       boost_active_q,
    output var  logic       pwm_od_out_q,
    output var  logic       pwm_od_oe_n_q,
    output var  logic       backlight_pwm_q,
    output var  logic [2:0] rgb_sink_on_q,
    output var  logic [1:0] rgb_current_q
);

    // ========================================================================
    // Input synchronisers
    // ========================================================================
    logic [4:0] meta_q;
    logic [4:0] sync_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {thermal_shutdown, low_supply_lockout, boost_overvoltage,
                       peak_limit_hit, sense_below_ref};
            sync_q <= meta_q;
        end
    end

    logic sense_low;
    logic peak_hit;
    logic ovp;
    logic lockout;
    logic hot;
    assign {hot, lockout, ovp, peak_hit, sense_low} = sync_q;

    // ========================================================================
    // Burst rate dividers and pattern generators
    // ========================================================================
    logic                      burst_half;
    logic                      rgb_half;
    logic                      pwm_tick;
    logic                      flash_tick;
    logic                      boost_burst_on;
    logic                      backlight_on;
    logic [2:0]                rgb_burst_on;
    logic [lpd_pkg::DIV_W-1:0] burst_period;
    logic [lpd_pkg::DIV_W-1:0] pwm_period;

    // The comparator-free rate choice is shared by boost and backlight.
    assign burst_period = burst_rate_select_bit ? lpd_pkg::DIV_W'(lpd_pkg::BURST_DIV_HI)
                                                : lpd_pkg::DIV_W'(lpd_pkg::BURST_DIV_LO);
    assign pwm_period   = lpd_pkg::DIV_W'(lpd_pkg::pwm_div(pwm_freq_sel) / PWM_DIV_SCALE);

    lpd_tick u_burst_tick (
        .clk     (clk),
        .sys_rst (sys_rst),
        .period  (burst_period),
        .tick_q  (burst_half)
    );

    lpd_tick u_rgb_tick (
        .clk     (clk),
        .sys_rst (sys_rst),
        .period  (lpd_pkg::DIV_W'(lpd_pkg::RGB_DIV)),
        .tick_q  (rgb_half)
    );

    lpd_tick u_pwm_tick (
        .clk     (clk),
        .sys_rst (sys_rst),
        .period  (pwm_period),
        .tick_q  (pwm_tick)
    );

    lpd_tick u_flash_tick (
        .clk     (clk),
        .sys_rst (sys_rst),
        .period  (lpd_pkg::DIV_W'(FLASH_TICK_CYC)),
        .tick_q  (flash_tick)
    );

    lpd_burst #(.W(lpd_pkg::BURST_W)) u_boost_burst (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .half_tick (burst_half),
        .duty      (boost_duty_setting),
        .on_q      (boost_burst_on)
    );

    lpd_burst #(.W(lpd_pkg::BURST_W)) u_backlight_burst (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .half_tick (burst_half),
        .duty      (backlight_duty_setting),
        .on_q      (backlight_on)
    );

    logic [4:0] rgb_duty [3];
    assign rgb_duty[0] = red_duty_setting;
    assign rgb_duty[1] = green_duty_setting;
    assign rgb_duty[2] = blue_duty_setting;

    for (genvar c = 0; c < 3; c++) begin : g_rgb
        lpd_burst #(.W(lpd_pkg::RGB_W)) u_rgb_burst (
            .clk       (clk),
            .sys_rst   (sys_rst),
            .half_tick (rgb_half),
            .duty      (rgb_duty[c]),
            .on_q      (rgb_burst_on[c])
        );
    end

    // ========================================================================
    // Boost converter control
    // ========================================================================
    lpd_pkg::lpd_boost_t state_q;
    lpd_pkg::lpd_boost_t state_d;
    logic [7:0]          step_cnt_q;
    logic [7:0]          step_cnt_d;
    logic [10:0]         on_cnt_q;
    logic [10:0]         on_cnt_d;
    logic                sw_d;
    logic                led_d;
    logic [1:0]          lim_d;
    logic                enable;
    logic                cycle_done;

    always_comb begin
        enable     = (boost_duty_setting != '0) && !lockout && !hot;
        state_d    = state_q;
        step_cnt_d = step_cnt_q;
        on_cnt_d   = '0;
        sw_d       = 1'b0;
        cycle_done = 1'b0;
        led_d      = enable && boost_burst_on;
        if (boost_switch_q) begin
            on_cnt_d = on_cnt_q + 1'b1;
            if (peak_hit || on_cnt_q >= 11'(lpd_pkg::MAX_ON_CYC - 1)) begin
                cycle_done = 1'b1;
            end else if (!led_switch_q || ovp || !enable) begin
                cycle_done = 1'b1;
            end else begin
                sw_d = 1'b1;
            end
        end else if (sense_low && led_switch_q && !ovp && enable
                     && state_q != lpd_pkg::LPD_OFF) begin
            sw_d = 1'b1;
        end
        case (state_q)
            lpd_pkg::LPD_OFF: begin
                step_cnt_d = '0;
                if (enable) begin
                    state_d = lpd_pkg::LPD_STEP1;
                end
            end
            lpd_pkg::LPD_STEP1, lpd_pkg::LPD_STEP2: begin
                if (cycle_done) begin
                    step_cnt_d = step_cnt_q + 1'b1;
                    if (step_cnt_q == 8'(lpd_pkg::SOFT_STEP_CYC - 1)) begin
                        state_d = (state_q == lpd_pkg::LPD_STEP1) ? lpd_pkg::LPD_STEP2
                                                                   : lpd_pkg::LPD_RUN;
                    end
                end
            end
            lpd_pkg::LPD_RUN: begin
                step_cnt_d = '0;
            end
            default: begin
                state_d = lpd_pkg::LPD_OFF;
            end
        endcase
        if (!enable) begin
            state_d = lpd_pkg::LPD_OFF;
            sw_d    = 1'b0;
            led_d   = 1'b0;
        end
        case (state_d)
            lpd_pkg::LPD_STEP1: lim_d = lpd_pkg::LIM_125MA;
            lpd_pkg::LPD_STEP2: lim_d = lpd_pkg::LIM_250MA;
            lpd_pkg::LPD_RUN:   lim_d = lpd_pkg::LIM_500MA;
            default:            lim_d = lpd_pkg::LIM_OFF;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q        <= lpd_pkg::LPD_OFF;
            step_cnt_q     <= '0;
            on_cnt_q       <= '0;
            boost_switch_q <= 1'b0;
            led_switch_q   <= 1'b0;
            boost_limit_q  <= lpd_pkg::LIM_OFF;
            boost_active_q <= 1'b0;
        end else begin
            state_q        <= state_d;
            step_cnt_q     <= step_cnt_d;
            on_cnt_q       <= on_cnt_d;
            boost_switch_q <= sw_d;
            led_switch_q   <= led_d;
            boost_limit_q  <= lim_d;
            boost_active_q <= (state_d != lpd_pkg::LPD_OFF);
        end
    end

    // ========================================================================
    // General open-drain PWM and backlight output
    // ========================================================================
    logic [3:0] pwm_cnt_q;
    logic [3:0] pwm_cnt_d;
    logic       pwm_on_d;

    always_comb begin
        pwm_cnt_d = pwm_tick ? pwm_cnt_q + 1'b1 : pwm_cnt_q;
        // Code 15 is widened to full on so that 100 % is reachable.
        pwm_on_d  = (pwm_cnt_q < pwm_duty_sel) || (pwm_duty_sel == 4'hf);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwm_cnt_q       <= '0;
            pwm_od_out_q    <= 1'b0;
            pwm_od_oe_n_q   <= 1'b1;
            backlight_pwm_q <= 1'b0;
        end else begin
            pwm_cnt_q       <= pwm_cnt_d;
            pwm_od_out_q    <= 1'b0;
            pwm_od_oe_n_q   <= !pwm_on_d;
            backlight_pwm_q <= backlight_on && (backlight_duty_setting != '0);
        end
    end

    // ========================================================================
    // RGB flasher
    // ========================================================================
    logic [6:0] flash_t_q;
    logic [6:0] flash_t_d;
    logic [6:0] period_ticks;
    logic [6:0] on_ticks;
    logic [2:0] sink_d;
    logic [6:0] rel;
    logic [6:0] offs;

    always_comb begin
        // Periods are whole half-seconds; code 0 means steady on.
        period_ticks = 7'(flash_period_sel) * lpd_pkg::HALF_SEC_TICKS
                     + lpd_pkg::HALF_SEC_TICKS;
        on_ticks     = 7'(flash_on_sel) + 7'h01;
        if (on_ticks > lpd_pkg::ON_TICKS_MAX) begin
            on_ticks = lpd_pkg::ON_TICKS_MAX;
        end
        flash_t_d = flash_t_q;
        if (!flash_enable) begin
            flash_t_d = '0;
        end else if (flash_tick) begin
            flash_t_d = (flash_t_q >= period_ticks - 7'h01) ? 7'h00 : flash_t_q + 7'h01;
        end
        sink_d = '0;
        rel    = '0;
        offs   = '0;
        for (int c = 0; c < 3; c++) begin
            offs = 7'(flash_phase_sel) * 7'(c);
            rel  = flash_t_q - offs;
            if (flash_enable && rgb_burst_on[c]) begin
                if (flash_period_sel == 4'h0 || (flash_t_q >= offs && rel < on_ticks)) begin
                    sink_d[c] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flash_t_q     <= '0;
            rgb_sink_on_q <= '0;
            rgb_current_q <= '0;
        end else begin
            flash_t_q     <= flash_t_d;
            rgb_sink_on_q <= sink_d;
            rgb_current_q <= flash_enable ? sink_current_sel : 2'h0;
        end
    end

endmodule
`default_nettype wire

// ---- lpd_top_test.sv ----
// Self-checking testbench for the LED and peripheral driver block.
`timescale 1ns/10ps
`default_nettype none
module lpd_top_test;
    logic       clk = 1'b0, sys_rst = 1'b1, slow = 1'b0, sense_below_ref, peak_limit_hit;
    logic       ovp = 1'b0, lock = 1'b0, therm = 1'b0, rate = 1'b1, fl_en = 1'b0;
    logic [7:0] boost_duty = 8'h00, bl_duty = 8'h00;
    logic [2:0] pwm_f = 3'h0;
    logic [3:0] pwm_d = 4'h0, fp = 4'h0;
    logic [1:0] cur_sel = 2'h0;
    logic [4:0] red_d = 5'h00, grn_d = 5'h00;
    logic       bsw, lsw, act, od_out, od_oe_n, bl, p;
    logic [1:0] lim, cur;
    logic [2:0] sink;
    int         bad_count = 0, cmp_count = 0, h[5], f, n;
    always #2.5 clk = ~clk;
    lpd_top #(.FLASH_TICK_CYC(50), .PWM_DIV_SCALE(100)) lpd_top_inst (
        .clk(clk), .sys_rst(sys_rst), .sense_below_ref(sense_below_ref), .peak_limit_hit(peak_limit_hit),
        .boost_overvoltage(ovp), .low_supply_lockout(lock), .thermal_shutdown(therm),
        .boost_duty_setting(boost_duty), .burst_rate_select_bit(rate), .pwm_freq_sel(pwm_f),
        .pwm_duty_sel(pwm_d), .backlight_duty_setting(bl_duty), .flash_enable(fl_en),
        .flash_period_sel(fp), .flash_on_sel(3'h0), .flash_phase_sel(2'h0), .sink_current_sel(cur_sel),
        .red_duty_setting(red_d), .green_duty_setting(grn_d), .blue_duty_setting(5'h1f),
        .boost_switch_q(bsw), .led_switch_q(lsw), .boost_limit_q(lim), .boost_active_q(act),
        .pwm_od_out_q(od_out), .pwm_od_oe_n_q(od_oe_n), .backlight_pwm_q(bl), .rgb_sink_on_q(sink),
        .rgb_current_q(cur));
    lpd_plant lpd_plant_inst (.clk(clk), .sys_rst(sys_rst), .boost_switch_q(bsw), .boost_limit_q(lim),
        .slow(slow), .peak_limit_hit(peak_limit_hit), .sense_below_ref(sense_below_ref));
    // ========================================================================
    // Tasks
    // ========================================================================
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask
    // Samples mid-cycle so every registered output has settled.
    task automatic measure(input int c);
        h = '{0, 0, 0, 0, 0};
        repeat (c) begin
            @(negedge clk);
            h[0] += int'(bl === 1'b1);
            h[1] += int'(lsw === 1'b1);
            h[2] += int'(sink[0] === 1'b1);
            h[3] += int'(sink[1] === 1'b1);
            h[4] += int'(od_oe_n === 1'b0);
        end
        @(posedge clk);
    endtask
    task automatic wait_lim(input logic [1:0] v);
        f = 0;
        p = bsw;
        for (n = 0; n < 200000 && lim !== v; n++) begin
            @(negedge clk);
            f += int'(p === 1'b1 && bsw === 1'b0);
            p = bsw;
        end
        if (lim !== v) begin
            bad_count++;
            conclude();
        end
    endtask
    // ========================================================================
    // Main sequence
    // ========================================================================
    initial begin
        cyc(20);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk({bsw, lsw, lim, act, od_out, od_oe_n, bl, sink, cur}, 32'h0040);
        @(posedge clk);
        boost_duty <= 8'hff;
        cyc(2);
        chk({act, lim}, {1'b1, lpd_pkg::LIM_125MA});
        wait_lim(lpd_pkg::LIM_250MA);
        chk(f, 256);
        wait_lim(lpd_pkg::LIM_500MA);
        chk(f, 256);
        slow <= 1'b1;
        for (n = 0; n < 5000 && bsw !== 1'b1; n++) @(negedge clk);
        for (f = 0; f < 2000 && bsw === 1'b1; f++) @(negedge clk);
        chk(f >= 1200 && f <= 1201, 1);
        @(posedge clk);
        slow <= 1'b0;
        ovp <= 1'b1;
        cyc(4);
        measure(100);
        chk(h[1] > 0 && bsw === 1'b0, 1);
        ovp <= 1'b0;
        cyc(4);
        for (n = 0; n < 200 && bsw !== 1'b1; n++) @(negedge clk);
        chk(bsw, 1);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            {lock, therm} <= i[0] ? 2'b01 : 2'b10;
            cyc(4);
            chk({act, bsw, lsw, lim}, 0);
            {lock, therm} <= 2'b00;
            cyc(4);
            chk({act, lim}, {1'b1, lpd_pkg::LIM_125MA});
        end
        for (int r = 0; r < 2; r++) begin
            n = r ? 2170 : 3201;
            rate <= r[0];
            bl_duty <= 8'h80;
            boost_duty <= 8'h80;
            cyc(2 * n);
            measure(4 * n);
            chk(h[0], 2 * n);
            chk(h[1], 2 * n);
        end
        bl_duty <= 8'h00;
        boost_duty <= 8'h00;
        red_d <= 5'h10;
        cyc(3);
        measure(2000);
        chk({h[0], h[2], act}, 0);
        fl_en <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            cur_sel <= c[1:0];
            cyc(2);
            chk(cur, c);
        end
        cyc(6250);
        measure(12500);
        chk(h[2], 6250);
        chk(h[3], 0);
        red_d <= 5'h1f;
        fp <= 4'hf;
        cyc(4000);
        measure(8000);
        chk(h[2], 100);
        for (int i = 0; i < 16; i++) begin
            pwm_f <= i[2:0];
            pwm_d <= i[3] ? 4'hf : 4'h0;
            cyc(300);
            measure(300);
            chk({h[4], od_out}, i[3] ? 600 : 0);
        end
        pwm_d <= 4'h8;
        cyc(2);
        measure(512);
        chk(h[4], 256);
        conclude();
    end
endmodule
`default_nettype wire
